// *** pclb_pkg.sv ***
// Purpose: Shared constants and types for the power-controller configuration register bank.
// Assumes: Byte-wide registers reached through the byte side of the serial register port.
// Notes: Times are in nanoseconds; cycle counts derive from the 250 MHz core clock.
package pclb_pkg;
	localparam logic [7:0] ADDR_CHARGER_CFG = 8'h07;
	localparam logic [7:0] ADDR_CHG_LED_ON = 8'h08;
	localparam logic [7:0] ADDR_CHG_LED_PER = 8'h09;
	localparam logic [7:0] ADDR_AUX_LED_ON = 8'h0a;
	localparam logic [7:0] ADDR_AUX_LED_PER = 8'h0b;
	localparam logic [7:0] ADDR_MAIN_CFG = 8'h0c;
	localparam logic [7:0] ADDR_CORE_CFG = 8'h0d;
	localparam int NUM_REGS = 7;
	localparam int IDX_CHARGER_CFG = 0;
	localparam int IDX_CHG_LED_ON = 1;
	localparam int IDX_CHG_LED_PER = 2;
	localparam int IDX_AUX_LED_ON = 3;
	localparam int IDX_AUX_LED_PER = 4;
	localparam int IDX_MAIN_CFG = 5;
	localparam int IDX_CORE_CFG = 6;
	localparam logic [7:0] RST_CHARGER_CFG = 8'h1b;
	localparam logic [7:0] RST_LED = 8'h00;
	localparam logic [7:0] RST_MAIN_CFG = 8'h32;
	localparam logic [7:0] RST_CORE_CFG = 8'h48;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Charger configuration fields.
	localparam int CHG_AUTO_WAIT = 7;
	localparam int CHG_RESTART = 6;
	localparam int CHG_TIMER_EN = 5;
	localparam int CHG_CUR_HI = 4;
	localparam int CHG_CUR_LO = 3;
	localparam int CHG_USB_500 = 2;
	localparam int CHG_USB_ALLOWED = 1;
	localparam int CHG_ENABLE = 0;
	// Indicator fields.
	localparam int LED_MODE_BIT = 7;
	localparam int LED_FIELD_W = 7;
	// Main converter fields.
	localparam int MAIN_FIXED_FREQ = 7;
	localparam int MAIN_UV_HI = 6;
	localparam int MAIN_UV_LO = 5;
	localparam int MAIN_SUPPLY_SEL = 4;
	localparam int MAIN_LP_ENABLE = 3;
	localparam int MAIN_DISCHARGE = 2;
	localparam int MAIN_VOLT_HI = 1;
	localparam int MAIN_VOLT_LO = 0;
	// Core converter fields.
	localparam int CORE_SLEEP_OFF = 7;
	localparam int CORE_CODE_B2 = 6;
	localparam int CORE_CODE_B1 = 5;
	localparam int CORE_CODE_B0 = 4;
	localparam int CORE_SLEEP_LO = 3;
	localparam int CORE_SLEEP_HI = 2;
	localparam int CORE_VIB = 1;
	localparam int CORE_DISCHARGE = 0;
	// Timing of the indicator generators.
	localparam int CLK_PERIOD_NS = 4;
	localparam int ON_STEP_NS = 10_000_000;
	localparam int PER_STEP_NS = 100_000_000;
	localparam int TEN_MS_CYCLES = ON_STEP_NS / CLK_PERIOD_NS;
	localparam logic [10:0] TICKS_PER_PERIOD_STEP = 11'(PER_STEP_NS / ON_STEP_NS);
	localparam int PRESCALE_W = 22;
	localparam int BLINK_CNT_W = 11;
	localparam int NUM_IND = 2;

	typedef enum logic [1:0] {
		PCLB_IND_AUTO = 2'b00,
		PCLB_IND_BLINK = 2'b01,
		PCLB_IND_OFF = 2'b10,
		PCLB_IND_ON = 2'b11
	} pclb_ind_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pclb_reg_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} pclb_reg_rsp_t;
endpackage

// *** pclb_regs_top.sv ***
// Purpose: Configuration register bank with charger, converter and indicator blink control.
// Assumes: Serial port logic hands over whole byte reads and writes synchronous to CORE_CLK.
// Notes: Strap pins are captured on the first edge after reset release.
`timescale 1ns/10ps
// Behaviour
// - Auto-wait clear: source present and supply above lockout forces on mode.
// - Auto-wait set: source present allows wait mode, converters not auto-started.
// - Charger restart bit clears charger timers and restarts the charge algorithm.
// - Timer enable defaults off; taper status shows comparator, else taper timer.
// - Charge current code selects full, three quarters, half or quarter.
// - Port limit bit picks 100 mA or 500 mA, ignored without port charging.
// - Port-charging bit zero forbids charging from the bus-powered input.
// - Charge enable zero blocks charging; adapter preferred when both valid.
// - Seven-bit on-time in 10 ms steps, 10 ms minimum.
// - Seven-bit period in 100 ms steps, 100 ms minimum.
// - Charge indicator modes: charger, blink, off, on; default charger.
// - Auxiliary indicator modes: off, blink, off, on.
// - Fixed-frequency bit keeps both converters out of pulse-skip operation.
// - Two-bit field selects lockout level 2.5, 2.75, 3.0 or 3.25 V.
// - Low-power pin with enable: supply select picks low-power or wait mode.
// - Low-power pin ignored while its enable bit is zero.
// - Main discharge bit discharges the main output while that converter is off.
// - Main voltage code 3.0, 2.75, 1.8, 3.3 V; low bit from strap.
// - Core voltage code has eight steps from 0.85 V to 1.6 V.
// - Core register default follows core strap: 1.3 V or 1.6 V.
// - Low-power mode uses zero then the two sleep bits as core code.
// - Core-off bit disables the core converter during low-power mode.
module pclb_regs_top #(
	parameter int TEN_MS_CYCLES = pclb_pkg::TEN_MS_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire pclb_pkg::pclb_reg_req_t REG_REQ,
	output pclb_pkg::pclb_reg_rsp_t REG_RSP,
	input wire logic IO_RAIL_DEFAULT_STRAP,
	input wire logic CPU_RAIL_DEFAULT_STRAP,
	input wire logic AC_VALID,
	input wire logic USB_VALID,
	input wire logic VCC_ABOVE_UNDERVOLTAGE_LOCKOUT,
	input wire logic LOWPOWER_REQUEST_PIN,
	input wire logic CHARGER_IND_REQ,
	input wire logic TAPER_CMP,
	input wire logic TAPER_TIMER,
	output logic FORCE_ON_MODE,
	output logic WAIT_MODE,
	output logic LOWPOWER_MODE,
	output logic CHARGER_RESTART,
	output logic CHARGE_TIMERS_ENABLE,
	output logic TAPER_STATUS,
	output logic [1:0] CHARGE_CURRENT_SEL,
	output logic USB_LIMIT_500MA,
	output logic CHARGE_FROM_AC,
	output logic CHARGE_FROM_USB,
	output logic FORCED_FIXED_FREQ,
	output logic [1:0] UNDERVOLTAGE_LEVEL,
	output logic MAIN_DISCHARGE_EN,
	output logic [1:0] IO_RAIL_SEL,
	output logic [2:0] CPU_RAIL_CODE,
	output logic CPU_RAIL_ENABLE,
	output logic CORE_DISCHARGE_EN,
	output logic VIB_ENABLE,
	output logic CHARGE_INDICATOR_PIN_OE,
	output logic AUX_INDICATOR_PIN_OE
);
	function automatic logic [3:0] addr_decode(input logic [7:0] a);
		logic [3:0] r;
		r = 4'hf;
		if (a >= pclb_pkg::ADDR_CHARGER_CFG && a <= pclb_pkg::ADDR_CORE_CFG) begin
			r = 4'(a - pclb_pkg::ADDR_CHARGER_CFG);
		end
		return r;
	endfunction

	function automatic logic ind_drive(input pclb_pkg::pclb_ind_mode_t m, input logic blink,
		input logic auto_level);
		logic r;
		r = 1'b0;
		unique case (m)
			pclb_pkg::PCLB_IND_AUTO: r = auto_level;
			pclb_pkg::PCLB_IND_BLINK: r = blink;
			pclb_pkg::PCLB_IND_OFF: r = 1'b0;
			pclb_pkg::PCLB_IND_ON: r = 1'b1;
		endcase
		return r;
	endfunction

	logic [7:0] regs_q [pclb_pkg::NUM_REGS];
	logic strap_done_q;
	logic [pclb_pkg::PRESCALE_W-1:0] prescale_q;
	logic tick_q;
	pclb_pkg::pclb_reg_rsp_t rsp_q;

	wire [3:0] req_idx = addr_decode(REG_REQ.addr);
	wire req_mapped = (req_idx != 4'hf);
	wire [7:0] chg = regs_q[pclb_pkg::IDX_CHARGER_CFG];
	wire [7:0] mcfg = regs_q[pclb_pkg::IDX_MAIN_CFG];
	wire [7:0] ccfg = regs_q[pclb_pkg::IDX_CORE_CFG];

	// Strap levels are caught by a clocked load after release, never by the reset itself.
	wire [7:0] main_strapped = {pclb_pkg::RST_MAIN_CFG[7:1], IO_RAIL_DEFAULT_STRAP};
	wire [7:0] core_strapped = {pclb_pkg::RST_CORE_CFG[7:6], {2{CPU_RAIL_DEFAULT_STRAP}},
		pclb_pkg::RST_CORE_CFG[3:0]};

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
		end
	end

	// Each byte is plain storage, apart from the one strap load into the main and core bytes; the restart bit is never cleared here.
	for (genvar g = 0; g < pclb_pkg::NUM_REGS; g++) begin : g_reg
		localparam logic [7:0] RST_VAL = (g == pclb_pkg::IDX_CHARGER_CFG) ? pclb_pkg::RST_CHARGER_CFG :
			(g == pclb_pkg::IDX_MAIN_CFG) ? pclb_pkg::RST_MAIN_CFG :
			(g == pclb_pkg::IDX_CORE_CFG) ? pclb_pkg::RST_CORE_CFG : pclb_pkg::RST_LED;
		wire host_wr = REG_REQ.wr && req_mapped && (req_idx == 4'(g));
		wire strap_ld = !strap_done_q && (g == pclb_pkg::IDX_MAIN_CFG || g == pclb_pkg::IDX_CORE_CFG);
		wire [7:0] strap_val = (g == pclb_pkg::IDX_MAIN_CFG) ? main_strapped : core_strapped;
		wire [7:0] reg_d = host_wr ? REG_REQ.wdata : strap_ld ? strap_val : regs_q[g];
		always_ff @(posedge CORE_CLK or posedge RST) begin
			if (RST) begin
				regs_q[g] <= RST_VAL;
			end else begin
				regs_q[g] <= reg_d;
			end
		end
	end

	// Read answer one cycle after the request; unmapped addresses read as zero.
	wire [7:0] rd_data = req_mapped ? regs_q[req_idx[2:0]] : pclb_pkg::READ_UNMAPPED;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= '{valid: REG_REQ.rd, data: (REG_REQ.rd ? rd_data : rsp_q.data)};
		end
	end
	assign REG_RSP = rsp_q;

	// A shared 10 ms tick keeps the per-channel counters narrow.
	wire prescale_wrap = (prescale_q == pclb_pkg::PRESCALE_W'(TEN_MS_CYCLES - 1));
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			prescale_q <= '0;
			tick_q <= 1'b0;
		end else begin
			prescale_q <= prescale_wrap ? '0 : prescale_q + 1'b1;
			tick_q <= prescale_wrap;
		end
	end

	logic [pclb_pkg::NUM_IND-1:0] blink_level;
	logic [pclb_pkg::NUM_IND-1:0] ind_mode_blink;
	for (genvar c = 0; c < pclb_pkg::NUM_IND; c++) begin : g_blink
		localparam int ON_IDX = (c == 0) ? pclb_pkg::IDX_CHG_LED_ON : pclb_pkg::IDX_AUX_LED_ON;
		localparam int PER_IDX = (c == 0) ? pclb_pkg::IDX_CHG_LED_PER : pclb_pkg::IDX_AUX_LED_PER;
		logic [pclb_pkg::BLINK_CNT_W-1:0] cnt_q;
		wire [pclb_pkg::BLINK_CNT_W-1:0] on_ticks =
			{4'h0, regs_q[ON_IDX][pclb_pkg::LED_FIELD_W-1:0]} + 11'h001;
		wire [pclb_pkg::BLINK_CNT_W-1:0] per_ticks = 11'(({4'h0,
			regs_q[PER_IDX][pclb_pkg::LED_FIELD_W-1:0]} + 11'h001) *
			pclb_pkg::TICKS_PER_PERIOD_STEP);
		wire [1:0] mode = {regs_q[ON_IDX][pclb_pkg::LED_MODE_BIT], regs_q[PER_IDX][pclb_pkg::LED_MODE_BIT]};
		wire is_blink = (mode == pclb_pkg::PCLB_IND_BLINK);
		wire cnt_end = (cnt_q >= per_ticks - 11'h001);
		wire [pclb_pkg::BLINK_CNT_W-1:0] cnt_d = !is_blink ? '0 :
			!tick_q ? cnt_q : cnt_end ? '0 : cnt_q + 11'h001;
		assign ind_mode_blink[c] = is_blink;
		// On-time longer than the period simply leaves the output on throughout.
		assign blink_level[c] = is_blink && (cnt_q < on_ticks);
		always_ff @(posedge CORE_CLK or posedge RST) begin
			if (RST) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_d;
			end
		end
	end

	wire [1:0] chg_mode = {regs_q[pclb_pkg::IDX_CHG_LED_ON][pclb_pkg::LED_MODE_BIT],
		regs_q[pclb_pkg::IDX_CHG_LED_PER][pclb_pkg::LED_MODE_BIT]};
	wire [1:0] aux_mode = {regs_q[pclb_pkg::IDX_AUX_LED_ON][pclb_pkg::LED_MODE_BIT],
		regs_q[pclb_pkg::IDX_AUX_LED_PER][pclb_pkg::LED_MODE_BIT]};
	wire chg_ind_d = ind_drive(pclb_pkg::pclb_ind_mode_t'(chg_mode), blink_level[0],
		CHARGER_IND_REQ);
	// The auxiliary pin has no charger owner, so code 00 behaves as off.
	wire aux_ind_d = ind_drive(pclb_pkg::pclb_ind_mode_t'(aux_mode), blink_level[1], 1'b0);

	wire source_present = AC_VALID || USB_VALID;
	wire force_on_d = !chg[pclb_pkg::CHG_AUTO_WAIT] && source_present && VCC_ABOVE_UNDERVOLTAGE_LOCKOUT;
	wire lp_request = LOWPOWER_REQUEST_PIN && mcfg[pclb_pkg::MAIN_LP_ENABLE];
	wire lowpower_d = lp_request && mcfg[pclb_pkg::MAIN_SUPPLY_SEL] && !force_on_d;
	// Auto-wait set never starts the converters; wait stays available.
	wire wait_d = lp_request && !mcfg[pclb_pkg::MAIN_SUPPLY_SEL] && !force_on_d;
	wire usb_allowed = chg[pclb_pkg::CHG_USB_ALLOWED];
	wire chg_en = chg[pclb_pkg::CHG_ENABLE];
	wire from_ac_d = chg_en && AC_VALID;
	wire from_usb_d = chg_en && usb_allowed && USB_VALID && !AC_VALID;
	wire usb_500_d = usb_allowed && chg[pclb_pkg::CHG_USB_500];
	wire taper_d = chg[pclb_pkg::CHG_TIMER_EN] ? TAPER_TIMER : TAPER_CMP;
	wire sleep_off = lowpower_d && ccfg[pclb_pkg::CORE_SLEEP_OFF];
	wire [2:0] core_code_d = lowpower_d ?
		{1'b0, ccfg[pclb_pkg::CORE_SLEEP_HI], ccfg[pclb_pkg::CORE_SLEEP_LO]} :
		{ccfg[pclb_pkg::CORE_CODE_B2], ccfg[pclb_pkg::CORE_CODE_B1], ccfg[pclb_pkg::CORE_CODE_B0]};

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			FORCE_ON_MODE <= 1'b0;
			WAIT_MODE <= 1'b0;
			LOWPOWER_MODE <= 1'b0;
			CHARGER_RESTART <= 1'b0;
			CHARGE_TIMERS_ENABLE <= 1'b0;
			TAPER_STATUS <= 1'b0;
			CHARGE_CURRENT_SEL <= 2'h0;
			USB_LIMIT_500MA <= 1'b0;
			CHARGE_FROM_AC <= 1'b0;
			CHARGE_FROM_USB <= 1'b0;
			FORCED_FIXED_FREQ <= 1'b0;
			UNDERVOLTAGE_LEVEL <= 2'h0;
			MAIN_DISCHARGE_EN <= 1'b0;
			IO_RAIL_SEL <= 2'h0;
			CPU_RAIL_CODE <= 3'h0;
			CPU_RAIL_ENABLE <= 1'b0;
			CORE_DISCHARGE_EN <= 1'b0;
			VIB_ENABLE <= 1'b0;
			CHARGE_INDICATOR_PIN_OE <= 1'b0;
			AUX_INDICATOR_PIN_OE <= 1'b0;
		end else begin
			FORCE_ON_MODE <= force_on_d;
			WAIT_MODE <= wait_d;
			LOWPOWER_MODE <= lowpower_d;
			CHARGER_RESTART <= chg[pclb_pkg::CHG_RESTART];
			CHARGE_TIMERS_ENABLE <= chg[pclb_pkg::CHG_TIMER_EN];
			TAPER_STATUS <= taper_d;
			CHARGE_CURRENT_SEL <= {chg[pclb_pkg::CHG_CUR_HI], chg[pclb_pkg::CHG_CUR_LO]};
			USB_LIMIT_500MA <= usb_500_d;
			CHARGE_FROM_AC <= from_ac_d;
			CHARGE_FROM_USB <= from_usb_d;
			FORCED_FIXED_FREQ <= mcfg[pclb_pkg::MAIN_FIXED_FREQ];
			UNDERVOLTAGE_LEVEL <= {mcfg[pclb_pkg::MAIN_UV_HI], mcfg[pclb_pkg::MAIN_UV_LO]};
			MAIN_DISCHARGE_EN <= mcfg[pclb_pkg::MAIN_DISCHARGE] && wait_d;
			IO_RAIL_SEL <= {mcfg[pclb_pkg::MAIN_VOLT_HI], mcfg[pclb_pkg::MAIN_VOLT_LO]};
			CPU_RAIL_CODE <= core_code_d;
			CPU_RAIL_ENABLE <= !sleep_off;
			CORE_DISCHARGE_EN <= ccfg[pclb_pkg::CORE_DISCHARGE] && (wait_d || sleep_off);
			VIB_ENABLE <= ccfg[pclb_pkg::CORE_VIB];
			CHARGE_INDICATOR_PIN_OE <= chg_ind_d;
			AUX_INDICATOR_PIN_OE <= aux_ind_d;
		end
	end
endmodule

// *** pclb_regs_assertions.sv ***
// Purpose: Port-level checks for the configuration register bank.
// Assumes: Sees only top-level ports; all mode outputs share one register stage.
// Notes: Outputs are zero in reset, so the core-enable relation skips the first edge after release.
`timescale 1ns/10ps
module pclb_regs_assertions (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire pclb_pkg::pclb_reg_req_t REG_REQ,
	input wire pclb_pkg::pclb_reg_rsp_t REG_RSP,
	input wire logic AC_VALID,
	input wire logic USB_VALID,
	input wire logic LOWPOWER_REQUEST_PIN,
	input wire logic TAPER_CMP,
	input wire logic TAPER_TIMER,
	input wire logic FORCE_ON_MODE,
	input wire logic WAIT_MODE,
	input wire logic LOWPOWER_MODE,
	input wire logic CHARGE_TIMERS_ENABLE,
	input wire logic TAPER_STATUS,
	input wire logic CHARGE_FROM_USB,
	input wire logic MAIN_DISCHARGE_EN,
	input wire logic [2:0] CPU_RAIL_CODE,
	input wire logic CPU_RAIL_ENABLE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	sequence seq_read_taken;
		REG_REQ.rd;
	endsequence
	sequence seq_answer;
		REG_RSP.valid;
	endsequence
	AST_READ_ANSWER: assert property (seq_read_taken |=> seq_answer)
		else $error("read not answered in the next cycle");
	AST_NO_SPURIOUS: assert property (!REG_REQ.rd |=> !REG_RSP.valid)
		else $error("answer without a read");
	AST_FORCE_EXCL: assert property (FORCE_ON_MODE |-> !WAIT_MODE && !LOWPOWER_MODE)
		else $error("wait or low-power active while forced on");
	AST_NO_SOURCE: assert property (!AC_VALID && !USB_VALID |=> !FORCE_ON_MODE)
		else $error("forced on without a source");
	AST_MODES_EXCL: assert property (!(WAIT_MODE && LOWPOWER_MODE))
		else $error("wait and low-power both active");
	AST_PIN_IGNORED: assert property (!LOWPOWER_REQUEST_PIN |=> !WAIT_MODE && !LOWPOWER_MODE)
		else $error("mode entered without the pin");
	AST_AC_PREFERRED: assert property (AC_VALID |=> !CHARGE_FROM_USB)
		else $error("port charging while adapter valid");
	AST_TAPER: assert property (1'b1 |=> TAPER_STATUS ==
		(CHARGE_TIMERS_ENABLE ? $past(TAPER_TIMER) : $past(TAPER_CMP)))
		else $error("taper status from wrong source");
	AST_MAIN_DISCH: assert property (MAIN_DISCHARGE_EN |-> WAIT_MODE)
		else $error("main discharge outside wait mode");
	AST_CORE_ON: assert property (!$past(RST) && !LOWPOWER_MODE |-> CPU_RAIL_ENABLE)
		else $error("core converter off outside low-power mode");
	AST_LP_CODE: assert property (LOWPOWER_MODE |-> !CPU_RAIL_CODE[2])
		else $error("low-power core code top bit set");
endmodule
bind pclb_regs_top pclb_regs_assertions chk (.CORE_CLK, .RST, .REG_REQ, .REG_RSP, .AC_VALID,
	.USB_VALID, .LOWPOWER_REQUEST_PIN, .TAPER_CMP, .TAPER_TIMER, .FORCE_ON_MODE, .WAIT_MODE,
	.LOWPOWER_MODE, .CHARGE_TIMERS_ENABLE, .TAPER_STATUS, .CHARGE_FROM_USB, .MAIN_DISCHARGE_EN,
	.CPU_RAIL_CODE, .CPU_RAIL_ENABLE);

// *** pclb_host_model.sv ***
// Purpose: Host side of the serial register port, issuing whole byte requests.
// Assumes: Requests start just after a rising edge and are taken at the next one.
// Notes: Idle address and data show the inverse of the last value, so stale bytes never match.
`timescale 1ns/10ps
module pclb_host_model (
	input wire logic clk,
	output pclb_pkg::pclb_reg_req_t req,
	input wire pclb_pkg::pclb_reg_rsp_t rsp
);
	initial req = '0;
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		req <= {2'b10, addr, data};
		@(posedge clk);
		req <= {2'b00, ~addr, ~data};
	endtask
	task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
		@(posedge clk);
		req <= {2'b01, addr, 8'h00};
		@(posedge clk);
		req <= {2'b00, ~addr, 8'hff};
		@(negedge clk);
		data = rsp.data;
		ok = rsp.valid;
	endtask
endmodule

// *** pmic_config_led_blink_regs_bench.sv ***
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Both straps high; tick shortened to 4 cycles so blink times are 4 and 40 cycles a step.
// Notes: Blink is measured after one full period, since the first pulse may be cut short.
`timescale 1ns/10ps
module pmic_config_led_blink_regs_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ac = 1'b0, usb = 1'b0, lp_pin = 1'b0, ind_req = 1'b1;
	pclb_pkg::pclb_reg_req_t req;
	pclb_pkg::pclb_reg_rsp_t rsp;
	logic force_on, wait_m, lp_m, restart, tmr_en, taper_st, usb500, from_ac, from_usb;
	logic ffreq, main_dis, cpu_en, cdis, vib;
	logic vcc = 1'b1;
	logic [1:0] cur_sel, uv_lvl, io_sel, oe;
	logic [2:0] cpu_code;
	logic [7:0] cfg;
	int err_count = 0;
	int n_compared = 0;
	logic [7:0] addr_t[8] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
	logic [7:0] rst_t[8] = '{8'h1b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h33, 8'h78, 8'h00};
	logic [7:0] cfg_t[4] = '{8'h07, 8'h05, 8'h06, 8'h87};
	logic [7:0] lp_cfg_t[4] = '{8'h1c, 8'h0c, 8'h14, 8'h1c};
	logic [6:0] lp_exp_t[4] = '{7'h21, 7'h5d, 7'h0d, 7'h0d};
	always #2 clk = ~clk;
	pclb_host_model host (.clk(clk), .req(req), .rsp(rsp));
	pclb_regs_top #(.TEN_MS_CYCLES(4)) dut (.CORE_CLK(clk), .RST(rst), .REG_REQ(req), .REG_RSP(rsp),
		.IO_RAIL_DEFAULT_STRAP(1'b1), .CPU_RAIL_DEFAULT_STRAP(1'b1), .AC_VALID(ac),
		.USB_VALID(usb), .VCC_ABOVE_UNDERVOLTAGE_LOCKOUT(vcc), .LOWPOWER_REQUEST_PIN(lp_pin),
		.CHARGER_IND_REQ(ind_req), .TAPER_CMP(1'b0), .TAPER_TIMER(1'b1),
		.FORCE_ON_MODE(force_on), .WAIT_MODE(wait_m), .LOWPOWER_MODE(lp_m),
		.CHARGER_RESTART(restart), .CHARGE_TIMERS_ENABLE(tmr_en), .TAPER_STATUS(taper_st),
		.CHARGE_CURRENT_SEL(cur_sel), .USB_LIMIT_500MA(usb500), .CHARGE_FROM_AC(from_ac),
		.CHARGE_FROM_USB(from_usb), .FORCED_FIXED_FREQ(ffreq), .UNDERVOLTAGE_LEVEL(uv_lvl),
		.MAIN_DISCHARGE_EN(main_dis), .IO_RAIL_SEL(io_sel), .CPU_RAIL_CODE(cpu_code),
		.CPU_RAIL_ENABLE(cpu_en), .CORE_DISCHARGE_EN(cdis), .VIB_ENABLE(vib),
		.CHARGE_INDICATOR_PIN_OE(oe[0]), .AUX_INDICATOR_PIN_OE(oe[1]));
	task automatic report_and_stop();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		chk({7'h00, v, d}, {8'h01, e});
	endtask
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask
	task automatic wait_lvl(input int w, input logic v, output int n);
		n = 0;
		while (oe[w] === v && n < 400) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic meas(input int w, input int hi, input int per);
		int n;
		int h;
		repeat (per) @(negedge clk);
		wait_lvl(w, 1'b1, n);
		wait_lvl(w, 1'b0, n);
		wait_lvl(w, 1'b1, h);
		wait_lvl(w, 1'b0, n);
		chk(16'(h), 16'(hi));
		chk(16'(h + n), 16'(per));
	endtask
	initial begin
		#60000;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 8; i++) chk_rd(addr_t[i], rst_t[i]);
		for (int i = 0; i < 8; i++) host.wr(addr_t[i], 8'h5a ^ 8'(i));
		for (int i = 0; i < 8; i++) chk_rd(addr_t[i], i < 7 ? 8'h5a ^ 8'(i) : 8'h00);
		for (int t = 0; t < 2; t++) begin
			host.wr(8'h07, 8'(t << 5));
			settle();
			chk(16'({tmr_en, taper_st}), 16'({t[0], t[0]}));
		end
		for (int c = 0; c < 4; c++) begin
			host.wr(8'h07, 8'(c << 3));
			settle();
			chk(16'(cur_sel), 16'(c));
		end
		host.wr(8'h07, 8'h5b);
		repeat (20) settle();
		chk(16'(restart), 16'h0001);
		host.wr(8'h07, 8'h1b);
		settle();
		chk(16'(restart), 16'h0000);
		for (int k = 0; k < 16; k++) begin
			cfg = cfg_t[k / 4];
			host.wr(8'h07, cfg);
			ac <= k[1];
			usb <= k[0];
			settle();
			chk(16'({force_on, usb500, from_ac, from_usb}), 16'({!cfg[7] & (k[1] | k[0]),
				cfg[2] & cfg[1], cfg[0] & k[1], cfg[0] & cfg[1] & k[0] & !k[1]}));
		end
		// A supply below lockout must keep the device out of forced on mode.
		host.wr(8'h07, 8'h07);
		vcc <= 1'b0;
		settle();
		chk(16'(force_on), 16'h0000);
		vcc <= 1'b1;
		host.wr(8'h07, 8'h87);
		for (int v = 0; v < 8; v++) begin
			host.wr(8'h0c, {v[2], v[1:0], 3'b000, v[1:0]});
			settle();
			chk(16'({ffreq, uv_lvl, io_sel}), 16'({v[2], v[1:0], v[1:0]}));
		end
		// Auto-wait stays set here, so sources cannot force the device on.
		host.wr(8'h0d, 8'hd8);
		for (int k = 0; k < 4; k++) begin
			host.wr(8'h0c, lp_cfg_t[k]);
			lp_pin <= (k != 3);
			settle();
			chk(16'({wait_m, lp_m, main_dis, cpu_en, cpu_code}), 16'(lp_exp_t[k]));
		end
		host.wr(8'h0d, 8'h03);
		settle();
		chk(16'({cdis, vib}), 16'h0001);
		host.wr(8'h0c, 8'h0c);
		lp_pin <= 1'b1;
		settle();
		chk(16'({cdis, vib}), 16'h0003);
		lp_pin <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			if (m == 1)
				continue;
			for (int a = 8; a < 12; a++) host.wr(8'(a), 8'((((a & 1) != 0) ? m : m >> 1) << 7));
			settle();
			chk(16'(oe), 16'({m == 3, m == 0 || m == 3}));
		end
		host.wr(8'h08, 8'h01);
		host.wr(8'h09, 8'h80);
		host.wr(8'h0a, 8'h02);
		host.wr(8'h0b, 8'h81);
		meas(0, 8, 40);
		meas(1, 12, 80);
		report_and_stop();
	end
endmodule
